// File: core/gpio_pkg.sv
package gpio_pkg;

    // ==========================================
    // special function space
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] SPACE_FIRST = 6'h00;
    localparam logic [5:0] SPACE_LAST = 6'h3f;

    // ==========================================
    // register offsets
    localparam logic [5:0] OFS_P0_LATCH = 6'h00;
    localparam logic [5:0] OFS_P1_LATCH = 6'h01;
    localparam logic [5:0] OFS_P1_DIR = 6'h09;
    localparam logic [5:0] OFS_P0_TYPE = 6'h0b;
    localparam logic [5:0] OFS_P0_PIN = 6'h0c;
    localparam logic [5:0] OFS_EXT_INT_CTRL = 6'h37;

    // ==========================================
    // field positions
    localparam int POS_INT_PIN_SEL = 6;
    localparam int POS_P1_INT0_PIN = 0;
    localparam int POS_P1_INT1_PIN = 1;

    // ==========================================
    // widths and reset values
    localparam int P0_W = 8;
    localparam int P1_W = 5;
    localparam logic [7:0] RST_P0_LATCH = 8'hff;
    localparam logic [7:0] RST_P0_TYPE = 8'h00;
    localparam logic [4:0] RST_P1_LATCH = 5'h00;
    localparam logic [4:0] RST_P1_DIR = 5'h00;
    localparam logic RST_INT_PIN_SEL = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================
    // instruction access states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FIRST = 2'b01,
        ST_SECOND = 2'b11
    } access_state_e;

    // ==========================================
    // cpu access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } space_req_s;

endpackage

// File: core/gpio_p0_p1.sv
`timescale 1ns/1ps
// Summary of operation
// - registers decoded inside the 0x00 to 0x3f special function space.
// - every output bit has a latch holding last written value.
// - pins sampled in first state of the read cycle.
// - driven pin values change in second state of the write cycle.
// - reset sets port 0 latch to all ones, output type to zero.
// - port 0 output type picks open-drain or push-pull per bit.
// - port 0 data read gives latch, pin register read gives pins.
// - port 1 five bits, per-bit direction, direction clears on reset.
// - port 1 output latch clears to zero on reset.
// - port 1 bit one edges flag interrupt even while output.
// - port 1 bit zero is io or interrupt input, io after reset.
// - select bit one means interrupt input; pin then kept as input.
module gpio_p0_p1 (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire gpio_pkg::space_req_s req,
    output logic req_ready,
    output logic req_done,
    output logic [7:0] rdata,
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    input wire logic [4:0] p1_in,
    output logic [4:0] p1_out,
    output logic [4:0] p1_oe,
    output logic int0_fall,
    output logic int1_edge
);

    // ==========================================
    // decode helpers
    function automatic logic in_space(input logic [5:0] a);
        in_space = (a >= gpio_pkg::SPACE_FIRST) && (a <= gpio_pkg::SPACE_LAST);
    endfunction

    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = in_space(a) && (a == ofs);
    endfunction

    // ==========================================
    // access sequencer
    gpio_pkg::access_state_e state_ff, nxt_state;
    gpio_pkg::space_req_s req_ff, nxt_req;
    logic take;

    always_comb begin
        take = ce && (state_ff == gpio_pkg::ST_IDLE) && (req.rd || req.wr);
        nxt_state = state_ff;
        nxt_req = req_ff;
        if (ce) begin
            case (state_ff)
                gpio_pkg::ST_IDLE: begin
                    if (take) begin
                        nxt_state = gpio_pkg::ST_FIRST;
                        nxt_req = req;
                    end
                end
                gpio_pkg::ST_FIRST: begin
                    nxt_state = gpio_pkg::ST_SECOND;
                end
                gpio_pkg::ST_SECOND: begin
                    nxt_state = gpio_pkg::ST_IDLE;
                end
                default: begin
                    nxt_state = gpio_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= gpio_pkg::ST_IDLE;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
        end
    end

    assign req_ready = ce && (state_ff == gpio_pkg::ST_IDLE);
    assign req_done = ce && (state_ff == gpio_pkg::ST_SECOND);

    // ==========================================
    // register file
    logic [7:0] p0_latch_ff, nxt_p0_latch;
    logic [7:0] p0_type_ff, nxt_p0_type;
    logic [4:0] p1_latch_ff, nxt_p1_latch;
    logic [4:0] p1_dir_ff, nxt_p1_dir;
    logic int_sel_ff, nxt_int_sel;
    logic wr_now;

    always_comb begin
        wr_now = ce && (state_ff == gpio_pkg::ST_SECOND) && req_ff.wr;
        nxt_p0_latch = p0_latch_ff;
        nxt_p0_type = p0_type_ff;
        nxt_p1_latch = p1_latch_ff;
        nxt_p1_dir = p1_dir_ff;
        nxt_int_sel = int_sel_ff;
        if (wr_now) begin
            if (hit(req_ff.addr, gpio_pkg::OFS_P0_LATCH)) begin
                nxt_p0_latch = req_ff.wdata;
            end
            if (hit(req_ff.addr, gpio_pkg::OFS_P0_TYPE)) begin
                nxt_p0_type = req_ff.wdata;
            end
            if (hit(req_ff.addr, gpio_pkg::OFS_P1_LATCH)) begin
                nxt_p1_latch = req_ff.wdata[4:0];
            end
            if (hit(req_ff.addr, gpio_pkg::OFS_P1_DIR)) begin
                nxt_p1_dir = req_ff.wdata[4:0];
            end
            if (hit(req_ff.addr, gpio_pkg::OFS_EXT_INT_CTRL)) begin
                nxt_int_sel = req_ff.wdata[gpio_pkg::POS_INT_PIN_SEL];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p0_latch_ff <= gpio_pkg::RST_P0_LATCH;
            p0_type_ff <= gpio_pkg::RST_P0_TYPE;
            p1_latch_ff <= gpio_pkg::RST_P1_LATCH;
            p1_dir_ff <= gpio_pkg::RST_P1_DIR;
            int_sel_ff <= gpio_pkg::RST_INT_PIN_SEL;
        end else begin
            p0_latch_ff <= nxt_p0_latch;
            p0_type_ff <= nxt_p0_type;
            p1_latch_ff <= nxt_p1_latch;
            p1_dir_ff <= nxt_p1_dir;
            int_sel_ff <= nxt_int_sel;
        end
    end

    // ==========================================
    // read path
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = gpio_pkg::READ_ZERO;
        if (hit(req_ff.addr, gpio_pkg::OFS_P0_LATCH)) begin
            rd_mux = p0_latch_ff;
        end else if (hit(req_ff.addr, gpio_pkg::OFS_P0_PIN)) begin
            rd_mux = p0_in;
        end else if (hit(req_ff.addr, gpio_pkg::OFS_P0_TYPE)) begin
            rd_mux = p0_type_ff;
        end else if (hit(req_ff.addr, gpio_pkg::OFS_P1_LATCH)) begin
            rd_mux = {3'h0, p1_latch_ff};
        end else if (hit(req_ff.addr, gpio_pkg::OFS_P1_DIR)) begin
            rd_mux = {3'h0, p1_dir_ff};
        end else if (hit(req_ff.addr, gpio_pkg::OFS_EXT_INT_CTRL)) begin
            rd_mux = {1'b0, int_sel_ff, 6'h00};
        end
        nxt_rdata = rdata_ff;
        if (ce && (state_ff == gpio_pkg::ST_FIRST) && req_ff.rd) begin
            nxt_rdata = rd_mux;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= gpio_pkg::READ_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;

    // ==========================================
    // pin drivers
    // open-drain or push-pull
    assign p0_out = p0_latch_ff;
    assign p0_oe = p0_type_ff | ~p0_latch_ff;

    assign p1_out = p1_latch_ff;
    assign p1_oe = p1_dir_ff & ~{4'h0, int_sel_ff};

    // ==========================================
    // external interrupt edge detect
    logic [1:0] p1_prev_ff, nxt_p1_prev;
    logic primed_ff, nxt_primed;
    logic int0_ff, nxt_int0;
    logic int1_ff, nxt_int1;

    always_comb begin
        nxt_p1_prev = p1_prev_ff;
        nxt_primed = primed_ff;
        nxt_int0 = int0_ff;
        nxt_int1 = int1_ff;
        if (ce) begin
            // first enabled edge only loads history, no false edge
            nxt_primed = 1'b1;
            nxt_p1_prev = p1_in[1:0];
            nxt_int0 = primed_ff && int_sel_ff && p1_prev_ff[gpio_pkg::POS_P1_INT0_PIN]
                && !p1_in[gpio_pkg::POS_P1_INT0_PIN];
            nxt_int1 = primed_ff && (p1_prev_ff[gpio_pkg::POS_P1_INT1_PIN]
                ^ p1_in[gpio_pkg::POS_P1_INT1_PIN]);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p1_prev_ff <= 2'h0;
            primed_ff <= 1'b0;
            int0_ff <= 1'b0;
            int1_ff <= 1'b0;
        end else begin
            p1_prev_ff <= nxt_p1_prev;
            primed_ff <= nxt_primed;
            int0_ff <= nxt_int0;
            int1_ff <= nxt_int1;
        end
    end

    assign int0_fall = int0_ff;
    assign int1_edge = int1_ff;

    // ==========================================
    // assertions
    AST_DECODE_UNMAPPED: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_now && (req_ff.addr == 6'h02))
        |=> ($stable(p0_latch_ff) && $stable(p1_latch_ff) && $stable(p1_dir_ff)))
    else $error("write to unmapped address changed a register");

    AST_LATCH_HOLDS: assert property (
        @(posedge clk) disable iff (!rstn)
        !(wr_now && (req_ff.addr == gpio_pkg::OFS_P0_LATCH)) |=> $stable(p0_latch_ff))
    else $error("port 0 latch changed without a write");

    AST_READ_FIRST_STATE: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && (state_ff == gpio_pkg::ST_FIRST) && req_ff.rd
            && (req_ff.addr == gpio_pkg::OFS_P0_PIN))
        |=> (rdata == $past(p0_in)))
    else $error("pin level not sampled in first state");

    AST_WRITE_SECOND_STATE: assert property (
        @(posedge clk) disable iff (!rstn)
        (take && req.wr && (req.addr == gpio_pkg::OFS_P1_LATCH)) ##1 ce ##1 ce
        |-> ($stable(p1_out) ##1 (p1_out == $past(req_ff.wdata[4:0]))))
    else $error("port 1 output not updated in second state");

    AST_RESET_P0: assert property (
        @(posedge clk) !rstn |-> ((p0_out == 8'hff) && (p0_oe == 8'h00)))
    else $error("port 0 reset values wrong");

    AST_OPEN_DRAIN_HIGH: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_now && (req_ff.addr == gpio_pkg::OFS_P0_TYPE) && (req_ff.wdata[0] == 1'b0)
            && p0_latch_ff[0])
        |=> !p0_oe[0])
    else $error("open-drain bit drove a high level");

    AST_PIN_VS_LATCH: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && (state_ff == gpio_pkg::ST_FIRST) && req_ff.rd
            && (req_ff.addr == gpio_pkg::OFS_P0_LATCH))
        |=> (rdata == $past(p0_latch_ff)))
    else $error("port 0 data read did not return latch");

    AST_RESET_P1_DIR: assert property (
        @(posedge clk) !rstn |-> (p1_oe == 5'h00))
    else $error("port 1 not all inputs in reset");

    AST_RESET_P1_LATCH: assert property (
        @(posedge clk) !rstn |-> (p1_out == 5'h00))
    else $error("port 1 latch not cleared in reset");

    AST_INT1_AS_OUTPUT: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && p1_oe[1] && (p1_in[1] != p1_prev_ff[1])) |=> int1_edge)
    else $error("edge on output pin not flagged");

    AST_INT0_SELECT: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && !int_sel_ff) |=> !int0_fall)
    else $error("interrupt flagged while pin is plain io");

    AST_INT0_INPUT: assert property (
        @(posedge clk) disable iff (!rstn)
        int_sel_ff |-> !p1_oe[0])
    else $error("interrupt pin driven as output");

    AST_P1_DRIVE: assert property (
        @(posedge clk) disable iff (!rstn)
        (wr_now && (req_ff.addr == gpio_pkg::OFS_P1_DIR) && req_ff.wdata[3])
        |=> (p1_oe[3] && (p1_out[3] == p1_latch_ff[3])))
    else $error("direction one did not enable driver");

endmodule

// File: bench/pin_circuit.sv
`timescale 1ns/1ps
module pin_circuit (
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe,
    input wire logic [7:0] ext_p0,
    input wire logic [7:0] ext_p0_en,
    input wire logic [4:0] p1_out,
    input wire logic [4:0] p1_oe,
    input wire logic [4:0] ext_p1,
    input wire logic [4:0] ext_p1_en,
    output logic [7:0] p0_in,
    output logic [4:0] p1_in
);
    // ==========================================
    // pin resolution, pull-up where undriven
    // outside levels held
    assign p0_in = (p0_oe & p0_out) | (~p0_oe & ((ext_p0_en & ext_p0) | ~ext_p0_en));
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & ((ext_p1_en & ext_p1) | ~ext_p1_en));
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic ce = 1'b1;
    logic flip = 1'b0;
    gpio_pkg::space_req_s req = '0;
    logic req_ready, req_done, int0_fall, int1_edge;
    logic [7:0] rdata, p0_in, p0_out, p0_oe, got, at_done;
    logic [7:0] ext_p0 = 8'h3c;
    logic [7:0] ext_p0_en = 8'hf0;
    logic [4:0] p1_in, p1_out, p1_oe;
    logic [4:0] ext_p1 = 5'h1f;
    logic [4:0] ext_p1_en = 5'h01;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_int0 = 0;
    int n_int1 = 0;
    int k;

    gpio_p0_p1 dut_u (.clk(clk), .rstn(rstn), .ce(ce), .req(req), .req_ready(req_ready),
        .req_done(req_done), .rdata(rdata), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe),
        .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .int0_fall(int0_fall),
        .int1_edge(int1_edge));
    pin_circuit pc_u (.p0_out(p0_out), .p0_oe(p0_oe), .ext_p0(ext_p0), .ext_p0_en(ext_p0_en),
        .p1_out(p1_out), .p1_oe(p1_oe), .ext_p1(ext_p1), .ext_p1_en(ext_p1_en),
        .p0_in(p0_in), .p1_in(p1_in));

    // ==========================================
    // clock, pulse counting, timeout
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (int0_fall === 1'b1) n_int0++;
        if (int1_edge === 1'b1) n_int1++;
        if (cycles == 2000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ==========================================
    // helpers
    function automatic logic [7:0] lvl(input logic [7:0] oe, o, en, x);
        return (oe & o) | (~oe & ((en & x) | ~en));
    endfunction
    task check(input string what, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task access(input logic rd, input logic wr, input logic [5:0] a, input logic [7:0] d);
        req.rd = rd;
        req.wr = wr;
        req.addr = a;
        req.wdata = d;
        while (req_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1;
        req = '0;
        if (flip) ext_p0 = ~ext_p0;
        @(posedge clk) #1;
        if (flip) ext_p0 = ~ext_p0;
        check("req_done", 8'h01, {7'h00, req_done});
        got = rdata;
        at_done = p0_out;
        @(posedge clk) #1;
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        access(1'b0, 1'b1, a, d);
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        access(1'b1, 1'b0, a, 8'h00);
        check("rdata", e, got);
    endtask
    task end_of_test;
        $display("mismatches %0d n_compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        #1 rstn = 1'b0;
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        check("p0_out", 8'hff, p0_out);
        check("p0_oe", 8'h00, p0_oe);
        check("p1_oe", 8'h00, {3'h0, p1_oe});
        check("p1_out", 8'h00, {3'h0, p1_out});
        ce = 1'b0;
        #1 check("req_ready", 8'h00, {7'h00, req_ready});
        @(posedge clk) #1 ce = 1'b1;
        rd(6'h00, 8'hff);
        rd(6'h0b, 8'h00);
        rd(6'h01, 8'h00);
        rd(6'h09, 8'h00);
        rd(6'h37, 8'h00);
        wr(6'h02, 8'h55);
        rd(6'h02, 8'h00);
        wr(6'h0c, 8'h00);
        rd(6'h0c, lvl(8'h00, 8'hff, ext_p0_en, ext_p0));
        wr(6'h00, 8'hf5);
        check("p0_out", 8'hff, at_done);
        check("p0_out", 8'hf5, p0_out);
        check("p0_oe", 8'h0a, p0_oe);
        rd(6'h00, 8'hf5);
        rd(6'h0c, lvl(8'h0a, 8'hf5, ext_p0_en, ext_p0));
        wr(6'h0b, 8'h0f);
        check("p0_oe", 8'h0f, p0_oe);
        flip = 1'b1;
        rd(6'h0c, lvl(8'h0f, 8'hf5, ext_p0_en, ~ext_p0));
        flip = 1'b0;
        wr(6'h00, 8'hff);
        wr(6'h0b, 8'h00);
        check("p0_oe", 8'h00, p0_oe);
        wr(6'h01, 8'hff);
        rd(6'h01, 8'h1f);
        wr(6'h09, 8'h1f);
        check("p1_oe", 8'h1f, {3'h0, p1_oe});
        check("p1_in", 8'h1f, {3'h0, p1_in});
        k = n_int1;
        wr(6'h01, 8'h1d);
        wr(6'h01, 8'h1f);
        repeat (2) @(posedge clk) #1;
        check("int1_edges", 8'h02, 8'(n_int1 - k));
        wr(6'h09, 8'h1e);
        k = n_int0;
        ext_p1[0] = 1'b0;
        repeat (3) @(posedge clk) #1;
        ext_p1[0] = 1'b1;
        repeat (3) @(posedge clk) #1;
        check("int0_falls", 8'h00, 8'(n_int0 - k));
        wr(6'h37, 8'hff);
        rd(6'h37, 8'h40);
        wr(6'h09, 8'h1f);
        check("p1_oe", 8'h1e, {3'h0, p1_oe});
        k = n_int0;
        ext_p1[0] = 1'b0;
        repeat (3) @(posedge clk) #1;
        ext_p1[0] = 1'b1;
        repeat (3) @(posedge clk) #1;
        check("int0_falls", 8'h01, 8'(n_int0 - k));
        end_of_test();
    end
endmodule
